// ### design/lics_pkg.sv
package lics_pkg;
    // Host port register addresses
    localparam logic [7:0] LICS_ADDR_INFO = 8'h11;
    localparam logic [7:0] LICS_ADDR_STAT = 8'h16;
    localparam logic [7:0] LICS_ADDR_MASK = 8'h17;
    localparam logic [7:0] LICS_ADDR_CTL2 = 8'h79;
    localparam logic [7:0] LICS_ADDR_CTL4 = 8'h7B;
    localparam logic [7:0] LICS_RST_VAL = 8'h00;
    // Control four fields
    localparam int LICS_MARK_INVERSION_ENABLE_BIT = 7;
    localparam int LICS_MARK_INVERSION_INVERT_BIT = 6;
    localparam int LICS_MPS_LO = 4;
    localparam int LICS_TT_LO = 2;
    // Control two fields
    localparam int LICS_ETS_BIT = 7;
    localparam int LICS_JITTER_CLOCK_MUX_BIT = 3;
    localparam int LICS_SCLD_BIT = 1;
    // Status bit positions
    localparam int LICS_SR_TXCLK = 0;
    localparam int LICS_SR_OPEN = 1;
    localparam int LICS_SR_CLIM = 2;
    localparam int LICS_SR_CARR = 3;
    localparam int LICS_SR_JITTER_FIFO_LIMIT_EVENT = 4;
    localparam int LICS_SR_SIG = 5;
    localparam int LICS_SR_TMR = 6;
    localparam int LICS_SR_INPUT_LEVEL_LOW = 7;
    localparam logic [7:0] LICS_DOUBLE_MASK = 8'h8F;
    // Master clock choices in kHz, index is the prescaler field
    localparam logic [3:0][15:0] LICS_MCLK_T1_KHZ = {16'h3040, 16'h1820, 16'h0C10, 16'h0608};
    localparam logic [3:0][15:0] LICS_MCLK_HI_KHZ = {16'h4000, 16'h2000, 16'h1000, 16'h0800};
    // Timing
    localparam int LICS_CLK_NS = 100;
    localparam int LICS_CHAN_T1_NS = 5181;
    localparam int LICS_CHAN_E1_NS = 3906;
    localparam logic [6:0] LICS_CHAN_T1_CYC = 7'(LICS_CHAN_T1_NS / LICS_CLK_NS);
    localparam logic [6:0] LICS_CHAN_E1_CYC = 7'(LICS_CHAN_E1_NS / LICS_CLK_NS);
    localparam int LICS_INPUT_LEVEL_LOW_MS = 50;
    localparam int LICS_INPUT_LEVEL_LOW_CYC = LICS_INPUT_LEVEL_LOW_MS * (1000000 / LICS_CLK_NS);
    localparam longint LICS_T1_RCLK_HZ = 1544000;
    localparam longint LICS_E1_RCLK_HZ = 2048000;
    localparam longint LICS_T1_SHORT_US = 42000;
    localparam longint LICS_E1_SHORT_US = 62500;
    localparam int LICS_T1_LONG_EDGES = int'(LICS_T1_RCLK_HZ);
    localparam int LICS_E1_LONG_EDGES = int'(LICS_E1_RCLK_HZ);
    localparam int LICS_T1_SHORT_EDGES = int'(LICS_T1_RCLK_HZ * LICS_T1_SHORT_US / 1000000);
    localparam int LICS_E1_SHORT_EDGES = int'(LICS_E1_RCLK_HZ * LICS_E1_SHORT_US / 1000000);
    // Pattern sync figures
    localparam logic [5:0] LICS_SYNC_MATCH_LAST = 6'h1F;
    localparam logic [5:0] LICS_ERR_WIN_LAST = 6'h3F;
    localparam logic [2:0] LICS_ERR_LIMIT_LAST = 3'h5;

    // Line-side levels arriving from analog or other clock domains
    typedef struct packed {
        logic [3:0] rx_level;
        logic tx_open_circuit;
        logic tx_current_limit_hit;
        logic code_word_detected;
        logic rx_carrier_lost;
        logic level_below_thresh;
        logic jitter_fifo_near;
        logic bert_bit_valid;
        logic bert_bit_err;
        logic liu_tx_clock_in;
        logic rx_clock;
        logic rx_tip_data;
    } lics_line_t;
endpackage

// ### design/lics_sync.sv
`timescale 1ns/100ps
module lics_sync #(
    parameter int W = 1
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_reg;

    ////////////////////////////////////////////////////////////////////////
    // Two flops per bit; the first stage feeds only the second
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge i_ref_clk) begin
                if (!i_rst_n) begin
                    meta_reg[g] <= 1'b0;
                    o_q[g] <= 1'b0;
                end else begin
                    meta_reg[g] <= i_d[g];
                    o_q[g] <= meta_reg[g];
                end
            end
        end
    endgenerate
endmodule

// ### design/lics_pattern_sync.sv
`timescale 1ns/100ps
module lics_pattern_sync (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_bit_valid,
    input wire logic i_bit_err,
    output logic o_sync
);
    import lics_pkg::*;
    logic [5:0] match_reg;
    logic [5:0] win_reg;
    logic [2:0] err_reg;

    ////////////////////////////////////////////////////////////////////////
    // Hunt for 32 clean bits, then watch 64-bit windows for six errors
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_sync <= 1'b0;
            match_reg <= 6'h00;
            win_reg <= 6'h00;
            err_reg <= 3'h0;
        end else if (i_bit_valid) begin
            if (!o_sync) begin
                if (i_bit_err) begin
                    match_reg <= 6'h00;
                end else if (match_reg == LICS_SYNC_MATCH_LAST) begin
                    o_sync <= 1'b1;
                    match_reg <= 6'h00;
                    win_reg <= 6'h00;
                    err_reg <= 3'h0;
                end else begin
                    match_reg <= match_reg + 6'h01;
                end
            end else if (i_bit_err && err_reg == LICS_ERR_LIMIT_LAST) begin
                o_sync <= 1'b0;
                win_reg <= 6'h00;
                err_reg <= 3'h0;
            end else if (win_reg == LICS_ERR_WIN_LAST) begin
                win_reg <= 6'h00;
                err_reg <= 3'h0;
            end else begin
                win_reg <= win_reg + 6'h01;
                err_reg <= err_reg + {2'h0, i_bit_err};
            end
        end
    end
endmodule

// ### design/lics_top.sv
`timescale 1ns/100ps
module lics_top #(
    parameter int P_INPUT_LEVEL_LOW_CYC = lics_pkg::LICS_INPUT_LEVEL_LOW_CYC,
    parameter int P_T1_LONG = lics_pkg::LICS_T1_LONG_EDGES,
    parameter int P_T1_SHORT = lics_pkg::LICS_T1_SHORT_EDGES,
    parameter int P_E1_LONG = lics_pkg::LICS_E1_LONG_EDGES,
    parameter int P_E1_SHORT = lics_pkg::LICS_E1_SHORT_EDGES,
    parameter int P_CHANNELS = 32
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_addr,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [7:0] i_wdata,
    input wire lics_pkg::lics_line_t i_line,
    input wire logic i_counter_update_select,
    input wire logic [P_CHANNELS-1:0] i_sig_chan_change,
    input wire logic [P_CHANNELS-1:0] i_signaling_change_enable,
    input wire logic i_tx_tip_data,
    output logic [7:0] o_rdata,
    output logic o_irq,
    output logic [3:0] o_tx_term_sel,
    output logic [15:0] o_mclk_khz,
    output logic o_e1_mode,
    output logic o_jitter_atten_clock_pll,
    output logic o_current_limit_en,
    output logic o_cmi_mode,
    output logic o_tx_line_tip,
    output logic o_rx_line_tip
);
    import lics_pkg::*;

    lics_line_t line_s;
    logic [7:0] ctl2_reg;
    logic [7:0] ctl4_reg;
    logic [7:0] mask_reg;
    logic [7:0] stat_reg;
    logic [7:0] stat_next;
    logic [7:0] info_reg;
    logic [7:0] pend_reg;
    logic [7:0] pend_next;
    logic [7:0] cond_prev_reg;
    logic [7:0] cond;
    logic [7:0] ev;
    logic [7:0] clr;
    logic [7:0] rd_mux;
    logic pattern_sync_status;
    logic tx_clock_lost_reg;
    logic [6:0] lost_cnt_reg;
    logic [6:0] lost_limit;
    logic txclk_prev_reg;
    logic rxclk_prev_reg;
    logic jfifo_prev_reg;
    logic input_level_low_reg;
    logic [19:0] input_level_low_cnt_reg;
    logic [20:0] tmr_cnt_reg;
    logic [20:0] tmr_limit;
    logic tmr_tick;
    logic e1;

    ////////////////////////////////////////////////////////////////////////
    // Every line-side level is asynchronous, so all of it is synchronised
    lics_sync #(
        .W($bits(lics_line_t))
    ) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_d(i_line),
        .o_q(line_s)
    );

    lics_pattern_sync u_psync (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_bit_valid(line_s.bert_bit_valid),
        .i_bit_err(line_s.bert_bit_err),
        .o_sync(pattern_sync_status)
    );

    assign e1 = ctl2_reg[LICS_ETS_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Writable registers
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            ctl2_reg <= LICS_RST_VAL;
            ctl4_reg <= LICS_RST_VAL;
            mask_reg <= LICS_RST_VAL;
        end else if (i_wr_en) begin
            case (i_addr)
                LICS_ADDR_CTL2: ctl2_reg <= i_wdata;
                LICS_ADDR_CTL4: ctl4_reg <= i_wdata;
                LICS_ADDR_MASK: mask_reg <= i_wdata;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decoded controls, all registered so the outputs come from flops
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_tx_term_sel <= 4'h1;
            o_mclk_khz <= LICS_MCLK_T1_KHZ[0];
            o_e1_mode <= 1'b0;
            o_jitter_atten_clock_pll <= 1'b0;
            o_current_limit_en <= 1'b1;
        end else begin
            o_tx_term_sel <= 4'h1 << ctl4_reg[LICS_TT_LO +: 2];
            // E1 ignores the mux bit; software is expected to hold it low
            if (e1 || ctl2_reg[LICS_JITTER_CLOCK_MUX_BIT]) begin
                o_mclk_khz <= LICS_MCLK_HI_KHZ[ctl4_reg[LICS_MPS_LO +: 2]];
            end else begin
                o_mclk_khz <= LICS_MCLK_T1_KHZ[ctl4_reg[LICS_MPS_LO +: 2]];
            end
            o_e1_mode <= e1;
            o_jitter_atten_clock_pll <= ctl2_reg[LICS_JITTER_CLOCK_MUX_BIT];
            o_current_limit_en <= !ctl2_reg[LICS_SCLD_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mark-inversion path; the invert bit only matters while coding is on
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_cmi_mode <= 1'b0;
            o_tx_line_tip <= 1'b0;
            o_rx_line_tip <= 1'b0;
        end else begin
            o_cmi_mode <= ctl4_reg[LICS_MARK_INVERSION_ENABLE_BIT];
            if (ctl4_reg[LICS_MARK_INVERSION_ENABLE_BIT]) begin
                o_tx_line_tip <= i_tx_tip_data ^ ctl4_reg[LICS_MARK_INVERSION_INVERT_BIT];
                o_rx_line_tip <= line_s.rx_tip_data ^ ctl4_reg[LICS_MARK_INVERSION_INVERT_BIT];
            end else begin
                o_tx_line_tip <= i_tx_tip_data;
                o_rx_line_tip <= line_s.rx_tip_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Real-time information register, unlatched
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            info_reg <= LICS_RST_VAL;
        end else begin
            info_reg <= {pattern_sync_status,
                         line_s.code_word_detected,
                         line_s.tx_current_limit_hit,
                         line_s.tx_open_circuit,
                         line_s.rx_level};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit clock watchdog; channel time depends on line standard
    assign lost_limit = e1 ? LICS_CHAN_E1_CYC : LICS_CHAN_T1_CYC;
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            txclk_prev_reg <= 1'b0;
            lost_cnt_reg <= 7'h00;
            tx_clock_lost_reg <= 1'b0;
        end else begin
            txclk_prev_reg <= line_s.liu_tx_clock_in;
            if (txclk_prev_reg != line_s.liu_tx_clock_in) begin
                lost_cnt_reg <= 7'h00;
                tx_clock_lost_reg <= 1'b0;
            end else if (lost_cnt_reg >= lost_limit) begin
                tx_clock_lost_reg <= 1'b1;
            end else begin
                lost_cnt_reg <= lost_cnt_reg + 7'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Level-under-threshold qualifier: filters short dips of the input
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            input_level_low_cnt_reg <= 20'h00000;
            input_level_low_reg <= 1'b0;
        end else if (!line_s.level_below_thresh) begin
            input_level_low_cnt_reg <= 20'h00000;
            input_level_low_reg <= 1'b0;
        end else if (input_level_low_cnt_reg >= 20'(P_INPUT_LEVEL_LOW_CYC - 1)) begin
            input_level_low_reg <= 1'b1;
        end else begin
            input_level_low_cnt_reg <= input_level_low_cnt_reg + 20'h00001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Update-interval timer counts rising edges of the recovered clock
    always_comb begin
        if (e1) begin
            tmr_limit = i_counter_update_select ? 21'(P_E1_SHORT - 1) : 21'(P_E1_LONG - 1);
        end else begin
            tmr_limit = i_counter_update_select ? 21'(P_T1_SHORT - 1) : 21'(P_T1_LONG - 1);
        end
    end
    assign tmr_tick = line_s.rx_clock && !rxclk_prev_reg && tmr_cnt_reg >= tmr_limit;
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            rxclk_prev_reg <= 1'b0;
            tmr_cnt_reg <= 21'h000000;
        end else begin
            rxclk_prev_reg <= line_s.rx_clock;
            if (line_s.rx_clock && !rxclk_prev_reg) begin
                tmr_cnt_reg <= tmr_tick ? 21'h000000 : tmr_cnt_reg + 21'h000001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status sources: conditions are levels; jitter and timer events are one-cycle pulses, the signaling event follows its inputs
    always_comb begin
        cond = 8'h00;
        cond[LICS_SR_TXCLK] = tx_clock_lost_reg;
        cond[LICS_SR_OPEN] = line_s.tx_open_circuit;
        cond[LICS_SR_CLIM] = line_s.tx_current_limit_hit;
        cond[LICS_SR_CARR] = line_s.rx_carrier_lost;
        cond[LICS_SR_INPUT_LEVEL_LOW] = input_level_low_reg;
        ev = 8'h00;
        ev[LICS_SR_JITTER_FIFO_LIMIT_EVENT] = line_s.jitter_fifo_near && !jfifo_prev_reg;
        ev[LICS_SR_SIG] = |(i_sig_chan_change & i_signaling_change_enable);
        ev[LICS_SR_TMR] = tmr_tick;
        clr = (i_rd_en && i_addr == LICS_ADDR_STAT) ? 8'hFF : 8'h00;
        // A set arriving with the read-clear wins, so no event is lost
        stat_next = (cond & LICS_DOUBLE_MASK) | ev | (stat_reg & ~clr);
        pend_next = ((cond ^ cond_prev_reg) & LICS_DOUBLE_MASK) | (pend_reg & ~clr);
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            stat_reg <= LICS_RST_VAL;
            pend_reg <= LICS_RST_VAL;
            cond_prev_reg <= LICS_RST_VAL;
            jfifo_prev_reg <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            pend_reg <= pend_next;
            cond_prev_reg <= cond;
            jfifo_prev_reg <= line_s.jitter_fifo_near;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt: edge-pending condition bits or set event bits, masked
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(((pend_reg & LICS_DOUBLE_MASK) | (stat_reg & ~LICS_DOUBLE_MASK))
                       & mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port; data is captured on the read strobe and held
    always_comb begin
        case (i_addr)
            LICS_ADDR_INFO: rd_mux = info_reg;
            LICS_ADDR_STAT: rd_mux = stat_reg;
            LICS_ADDR_MASK: rd_mux = mask_reg;
            LICS_ADDR_CTL2: rd_mux = ctl2_reg;
            LICS_ADDR_CTL4: rd_mux = ctl4_reg;
            default: rd_mux = 8'h00;
        endcase
    end
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
        end else if (i_rd_en) begin
            o_rdata <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    term_decode_a: assert property (ctl4_reg[3:2] == 2'b10 |=> o_tx_term_sel == 4'h4)
        else $error("termination select not decoded to 100 ohm");
    mclk_t1_a: assert property (!e1 && !ctl2_reg[3] && ctl4_reg[5:4] == 2'b11
        |=> o_mclk_khz == 16'h3040)
        else $error("T1 prescaler 11 not 12.352 MHz");
    mclk_e1_a: assert property (e1 && ctl4_reg[5:4] == 2'b00 |=> o_mclk_khz == 16'h0800)
        else $error("E1 prescaler 00 not 2.048 MHz");
    cmi_invert_a: assert property (ctl4_reg[7:6] == 2'b11
        |=> o_tx_line_tip == !$past(i_tx_tip_data))
        else $error("inverted tip not inverted");
    cmi_off_a: assert property (!ctl4_reg[7] |=> !o_cmi_mode
        && o_tx_line_tip == $past(i_tx_tip_data))
        else $error("coding active while disabled");
    level_info_a: assert property (##1 info_reg[3:0] == $past(line_s.rx_level))
        else $error("receive level code stale");
    clk_lost_a: assert property ($rose(tx_clock_lost_reg)
        |-> lost_cnt_reg >= lost_limit && $past(txclk_prev_reg) == txclk_prev_reg)
        else $error("clock loss flagged with recent transition");
    jitter_fifo_limit_event_clear_a: assert property (clr[4] && !ev[4] |=> !stat_reg[4])
        else $error("limit event not cleared by read");
    jitter_fifo_limit_event_set_a: assert property (ev[4] |=> stat_reg[4])
        else $error("limit event lost");
    timer_a: assert property (tmr_tick |=> stat_reg[6])
        else $error("timer event not set");
    edge_irq_a: assert property (mask_reg[3] && $fell(cond[3]) && $stable(mask_reg)
        |-> ##[1:2] o_irq)
        else $error("falling condition edge gave no interrupt");
    irq_mask_a: assert property (mask_reg == 8'h00 |=> !o_irq)
        else $error("interrupt with all bits masked");
    input_level_low_a: assert property ($rose(input_level_low_reg)
        |-> $past(line_s.level_below_thresh, 2))
        else $error("level flag set without low input");
    // Real-time bits must track their synchronised sources one cycle later
    info_open_a: assert property (##1 info_reg[4]
        == $past(line_s.tx_open_circuit)) else $error("open-circuit bit stale");
    info_clim_a: assert property (##1 info_reg[5]
        == $past(line_s.tx_current_limit_hit)) else $error("current-limit bit stale");
    info_code_a: assert property (##1 info_reg[6]
        == $past(line_s.code_word_detected)) else $error("code-detect bit stale");
    info_sync_a: assert property (##1 info_reg[7]
        == $past(pattern_sync_status)) else $error("pattern sync bit stale");
    carrier_set_a: assert property (line_s.rx_carrier_lost |=> stat_reg[3])
        else $error("carrier loss not latched");
    sig_event_a: assert property (ev[5] |=> stat_reg[5])
        else $error("signaling change event lost");
    irq_event_a: assert property (|(stat_reg & mask_reg & ~LICS_DOUBLE_MASK)
        |=> o_irq) else $error("pending enabled event gave no interrupt");
    pll_src_a: assert property (##1 o_jitter_atten_clock_pll
        == $past(ctl2_reg[3])) else $error("jitter clock source not followed");
    e1_mode_a: assert property (##1 o_e1_mode == $past(e1))
        else $error("line standard not followed");
    open_set_a: assert property (line_s.tx_open_circuit |=> stat_reg[1])
        else $error("open-circuit condition not latched");
    clim_set_a: assert property (line_s.tx_current_limit_hit |=> stat_reg[2])
        else $error("current-limit condition not latched");

    sig_c: cover property (ev[LICS_SR_SIG]);
    irq_c: cover property ($rose(o_irq));
    sync_c: cover property ($rose(pattern_sync_status));
    lost_c: cover property ($rose(tx_clock_lost_reg));
    timer_c: cover property (tmr_tick);
endmodule

// ### sim/lics_line_model.sv
`timescale 1ns/100ps
module lics_line_model (
    input wire logic i_ref_clk,
    input wire lics_pkg::lics_line_t i_ctl,
    input wire logic i_tx_run,
    input wire logic i_rx_run,
    output lics_pkg::lics_line_t o_line
);
    import lics_pkg::*;
    logic tx_q = 1'b0;
    logic rx_q = 1'b0;
    logic rx_div = 1'b0;
    // Line clocks; the transmit clock freezes when stopped, as a dead source would
    always_ff @(negedge i_ref_clk) begin
        rx_div <= ~rx_div;
        if (i_tx_run) tx_q <= ~tx_q;
        if (i_rx_run && rx_div) rx_q <= ~rx_q;
    end
    // Levels come from the bench, clocks from here
    always_comb begin
        o_line = i_ctl;
        o_line.liu_tx_clock_in = tx_q;
        o_line.rx_clock = rx_q;
    end
endmodule

// ### sim/lics_top_tb.sv
`timescale 1ns/100ps
module lics_top_tb;
    import lics_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] wdata = 8'h00;
    lics_line_t line_ctl = '0;
    lics_line_t line_bus;
    logic upd_sel = 1'b1;
    logic [31:0] chan_chg = 32'h0;
    logic [31:0] chan_en = 32'h1;
    logic tip = 1'b0;
    logic tx_run = 1'b1;
    logic rx_run = 1'b0;
    logic [7:0] rdata;
    logic irq;
    logic [3:0] term;
    logic [15:0] mclk;
    logic e1;
    logic pll;
    logic lim;
    logic cmi;
    logic tx_tip;
    logic rx_tip;
    int fail_count = 0;
    int total_checks = 0;
    ////////////////////////////////////////////////////////////////////////
    // Short counts keep the timed bits reachable in a few dozen cycles
    lics_top #(.P_INPUT_LEVEL_LOW_CYC(20), .P_T1_LONG(10), .P_T1_SHORT(5), .P_E1_LONG(10),
        .P_E1_SHORT(5)) dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_addr(addr),
        .i_wr_en(wr_en), .i_rd_en(rd_en), .i_wdata(wdata), .i_line(line_bus),
        .i_counter_update_select(upd_sel), .i_sig_chan_change(chan_chg),
        .i_signaling_change_enable(chan_en), .i_tx_tip_data(tip), .o_rdata(rdata),
        .o_irq(irq), .o_tx_term_sel(term), .o_mclk_khz(mclk), .o_e1_mode(e1),
        .o_jitter_atten_clock_pll(pll), .o_current_limit_en(lim), .o_cmi_mode(cmi),
        .o_tx_line_tip(tx_tip), .o_rx_line_tip(rx_tip));
    lics_line_model line_model (.i_ref_clk(clk), .i_ctl(line_ctl), .i_tx_run(tx_run),
        .i_rx_run(rx_run), .o_line(line_bus));
    // 10 MHz reference
    always #50 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (fail_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Host strobes last one cycle and change only at the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        cyc(1);
        wr_en = 1'b0;
        cyc(1);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        addr = a;
        rd_en = 1'b1;
        cyc(1);
        rd_en = 1'b0;
        chk({8'h00, rdata & m}, {8'h00, e});
        cyc(1);
    endtask
    task automatic bits(input int n, input logic err);
        repeat (n) begin
            line_ctl.bert_bit_valid = 1'b1;
            line_ctl.bert_bit_err = err;
            cyc(1);
            line_ctl.bert_bit_valid = 1'b0;
            cyc(1);
        end
        cyc(4);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rdchk(LICS_ADDR_INFO, 8'hFF, 8'h00);
        rdchk(LICS_ADDR_STAT, 8'hFF, 8'h00);
        chk(term, 16'h0001);
        chk(mclk, 16'h0608);
        chk(lim, 16'h0001);
        wr(LICS_ADDR_MASK, 8'hA5);
        rdchk(LICS_ADDR_MASK, 8'hFF, 8'hA5);
        wr(LICS_ADDR_INFO, 8'hFF);
        rdchk(LICS_ADDR_INFO, 8'hFF, 8'h00);
        rdchk(8'h20, 8'hFF, 8'h00);
        wr(LICS_ADDR_MASK, 8'h00);
    endtask
    task automatic t_ctl();
        logic [7:0] mode [3] = '{8'h00, 8'h08, 8'h80};
        for (int t = 0; t < 4; t++) begin
            wr(LICS_ADDR_CTL4, 8'(t * 4));
            cyc(2);
            chk(term, 16'(1 << t));
        end
        // E1 entry keeps the mux bit clear
        for (int m = 0; m < 3; m++) begin
            wr(LICS_ADDR_CTL2, mode[m]);
            for (int p = 0; p < 4; p++) begin
                wr(LICS_ADDR_CTL4, 8'(p * 16));
                cyc(2);
                chk(mclk, (m == 0) ? LICS_MCLK_T1_KHZ[p] : LICS_MCLK_HI_KHZ[p]);
            end
            chk(e1, mode[m][7]);
            chk(pll, mode[m][3]);
        end
        wr(LICS_ADDR_CTL2, 8'h02);
        cyc(2);
        chk(lim, 16'h0000);
        wr(LICS_ADDR_CTL2, 8'h00);
    endtask
    task automatic t_cmi();
        tip = 1'b1;
        wr(LICS_ADDR_CTL4, 8'h40);
        cyc(3);
        chk(cmi, 16'h0000);
        chk(tx_tip, 16'h0001);
        wr(LICS_ADDR_CTL4, 8'hC0);
        line_ctl.rx_tip_data = 1'b1;
        cyc(4);
        chk(cmi, 16'h0001);
        chk(tx_tip, 16'h0000);
        chk(rx_tip, 16'h0000);
        wr(LICS_ADDR_CTL4, 8'h00);
    endtask
    task automatic t_info();
        line_ctl.rx_level = 4'hF;
        line_ctl.tx_open_circuit = 1'b1;
        line_ctl.tx_current_limit_hit = 1'b1;
        line_ctl.code_word_detected = 1'b1;
        cyc(4);
        rdchk(LICS_ADDR_INFO, 8'hFF, 8'h7F);
        line_ctl = '0;
        cyc(4);
        rdchk(LICS_ADDR_INFO, 8'hFF, 8'h00);
        rdchk(LICS_ADDR_STAT, 8'h06, 8'h06);
        rdchk(LICS_ADDR_STAT, 8'h06, 8'h00);
    endtask
    task automatic t_carrier();
        wr(LICS_ADDR_MASK, 8'h08);
        for (int k = 0; k < 2; k++) begin
            line_ctl.rx_carrier_lost = (k == 0);
            cyc(5);
            chk(irq, 16'h0001);
            rdchk(LICS_ADDR_STAT, 8'h08, 8'h08);
            cyc(2);
            chk(irq, 16'h0000);
        end
        rdchk(LICS_ADDR_STAT, 8'h08, 8'h00);
        wr(LICS_ADDR_MASK, 8'h00);
        line_ctl.rx_carrier_lost = 1'b1;
        cyc(5);
        chk(irq, 16'h0000);
        line_ctl.rx_carrier_lost = 1'b0;
        cyc(5);
        rdchk(LICS_ADDR_STAT, 8'h08, 8'h08);
    endtask
    task automatic t_events();
        wr(LICS_ADDR_MASK, 8'h30);
        line_ctl.jitter_fifo_near = 1'b1;
        cyc(1);
        line_ctl.jitter_fifo_near = 1'b0;
        cyc(5);
        chk(irq, 16'h0001);
        rdchk(LICS_ADDR_STAT, 8'h10, 8'h10);
        rdchk(LICS_ADDR_STAT, 8'h10, 8'h00);
        cyc(1);
        chk(irq, 16'h0000);
        for (int c = 1; c >= 0; c--) begin
            chan_chg = 32'(1 << c);
            cyc(1);
            chan_chg = 32'h0;
            cyc(3);
            rdchk(LICS_ADDR_STAT, 8'h20, (c == 0) ? 8'h20 : 8'h00);
        end
        wr(LICS_ADDR_MASK, 8'h00);
    endtask
    task automatic t_sync();
        bits(31, 1'b0);
        rdchk(LICS_ADDR_INFO, 8'h80, 8'h00);
        bits(1, 1'b0);
        rdchk(LICS_ADDR_INFO, 8'h80, 8'h80);
        bits(5, 1'b1);
        rdchk(LICS_ADDR_INFO, 8'h80, 8'h80);
        bits(1, 1'b1);
        rdchk(LICS_ADDR_INFO, 8'h80, 8'h00);
    endtask
    task automatic t_timed();
        tx_run = 1'b0;
        cyc(70);
        rdchk(LICS_ADDR_STAT, 8'h01, 8'h01);
        tx_run = 1'b1;
        line_ctl.level_below_thresh = 1'b1;
        cyc(12);
        rdchk(LICS_ADDR_STAT, 8'h80, 8'h00);
        cyc(20);
        rdchk(LICS_ADDR_STAT, 8'h80, 8'h80);
        rx_run = 1'b1;
        cyc(40);
        rdchk(LICS_ADDR_STAT, 8'h40, 8'h40);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Watchdog sized well past the roughly 450 cycles the tests need
    initial begin
        #2000000;
        fail_count++;
        complete_run();
    end
    initial begin
        cyc(10);
        rst_n = 1'b1;
        t_regs();
        t_ctl();
        t_cmi();
        t_info();
        t_carrier();
        t_events();
        t_sync();
        t_timed();
        complete_run();
    end
endmodule
